// ===== design/omr_pkg.sv
// Purpose: Shared constants and carriers for the OR/move/rotate execution block.
// Assumes: 14-bit instruction words, 128-entry file space, 13-bit program counter.
// Notes: Opcode patterns are a 14-bit encoding chosen for this block.
package omr_pkg;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned STACK_PTR_W = 3;
  localparam int unsigned FILE_DEPTH = 128;
  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned CARRY_IN_BIT = 0;
  localparam int unsigned MSB_BIT = 7;
  // ----------------------------------------
  // Opcode patterns
  // ----------------------------------------
  localparam logic [5:0] OP_OR_WORK_WITH_FILE = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE_TO_DEST = 6'h08;
  localparam logic [5:0] OP_ROTATE_LEFT = 6'h0d;
  localparam logic [5:0] OP_OR_LITERAL = 6'h38;
  localparam logic [3:0] OP_LOAD_LITERAL_HI = 4'hc;
  localparam logic [6:0] OP_STORE_WORK_HI = 7'h01;
  localparam logic [13:0] OP_RETURN_FROM_ISR = 14'h0009;
  localparam logic [13:0] OP_IDLE = 14'h0000;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;

  typedef enum {
    OMR_IDLE_INSTRUCTION,
    OMR_OR_LITERAL_INTO_WORK,
    OMR_LOAD_LITERAL_TO_WORK,
    OMR_OR_WORK_WITH_FILE,
    OMR_STORE_WORK_TO_FILE,
    OMR_MOVE_FILE_TO_DEST,
    OMR_ROTATE_LEFT_VIA_CARRY,
    OMR_RETURN_FROM_ISR
  } omr_op_t;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } omr_insn_t;

  typedef struct packed {
    logic zero;
    logic carry;
  } omr_flags_t;
endpackage : omr_pkg

// ===== design/omr_decode.sv
// Purpose: Decodes an instruction word into an operation class.
// Assumes: Word is valid when sampled by the caller.
// Notes: Unknown words decode as idle so they leave state alone.
`timescale 1ns/1ps
module omr_decode (
  input wire logic [13:0] word,
  output omr_pkg::omr_op_t op
);
  always_comb begin
    op = omr_pkg::OMR_IDLE_INSTRUCTION;
    if (word == omr_pkg::OP_RETURN_FROM_ISR) begin
      op = omr_pkg::OMR_RETURN_FROM_ISR;
    end else if (word[13:7] == omr_pkg::OP_STORE_WORK_HI) begin
      op = omr_pkg::OMR_STORE_WORK_TO_FILE;
    end else if (word[13:12] == 2'h0) begin
      if (word[13:8] == omr_pkg::OP_OR_WORK_WITH_FILE) begin
        op = omr_pkg::OMR_OR_WORK_WITH_FILE;
      end else if (word[13:8] == omr_pkg::OP_MOVE_FILE_TO_DEST) begin
        op = omr_pkg::OMR_MOVE_FILE_TO_DEST;
      end else if (word[13:8] == omr_pkg::OP_ROTATE_LEFT) begin
        op = omr_pkg::OMR_ROTATE_LEFT_VIA_CARRY;
      end
    end else if (word[13:8] == omr_pkg::OP_OR_LITERAL) begin
      op = omr_pkg::OMR_OR_LITERAL_INTO_WORK;
    end else if (word[13:10] == omr_pkg::OP_LOAD_LITERAL_HI) begin
      op = omr_pkg::OMR_LOAD_LITERAL_TO_WORK;
    end
  end
endmodule : omr_decode

// ===== design/omr_exec.sv
// Purpose: Executes OR, literal load, moves, rotate left and return from interrupt.
// Assumes: One instruction per enabled clock; words arrive synchronous to core_clk.
// Notes: File register space is held locally as a 128-entry array.
`timescale 1ns/1ps
module omr_exec (
  input wire logic core_clk,
  input wire logic reset,
  input omr_pkg::omr_insn_t insn,
  input wire logic push_valid,
  input wire logic [12:0] push_addr,
  output logic [7:0] work_q,
  output omr_pkg::omr_flags_t flags_q,
  output logic global_irq_enable_q,
  output logic [12:0] program_counter_q,
  output logic pc_load_q,
  output logic file_we_q,
  output logic [6:0] file_addr_q,
  output logic [7:0] file_wdata_q
);
  // ----------------------------------------
  // Decode and operand fetch
  // ----------------------------------------
  omr_pkg::omr_op_t op;
  // The file array has no reset, so an entry must be written before it is read.
  logic [7:0] file_mem [omr_pkg::FILE_DEPTH];
  logic [7:0] lit;
  logic [6:0] faddr;
  logic dest_file;
  logic [7:0] fval;
  logic [7:0] result;
  logic to_work;
  logic to_file;
  logic upd_zero;
  logic upd_carry;
  logic new_carry;
  logic [12:0] stack_q [omr_pkg::STACK_DEPTH];
  logic [2:0] sp_q;
  logic [2:0] sp_top;
  logic [2:0] sp_d;
  logic [7:0] rot_val;
  logic is_return;
  logic take_push;

  omr_decode u_decode (
    .word(insn.word),
    .op(op)
  );

  assign lit = insn.word[7:0];
  assign faddr = insn.word[6:0];
  assign dest_file = insn.word[omr_pkg::DEST_BIT];
  assign fval = file_mem[faddr];
  assign sp_top = sp_q - 3'h1;
  assign is_return = insn.valid && (op == omr_pkg::OMR_RETURN_FROM_ISR);
  // A push that meets a return is dropped, so the entry being popped is never overwritten.
  assign take_push = push_valid && !is_return;

  // ----------------------------------------
  // Rotate network
  // ----------------------------------------
  // Each bit takes its lower neighbour and bit 0 takes the old carry, so the
  // rotate needs no shifter and no extra carry stage.
  for (genvar gi = 0; gi < omr_pkg::DATA_W; gi++) begin : g_rot
    if (gi == omr_pkg::CARRY_IN_BIT) begin : g_low
      assign rot_val[gi] = flags_q.carry;
    end else begin : g_high
      assign rot_val[gi] = fval[gi - 1];
    end
  end

  // ----------------------------------------
  // Result and write-back selection
  // ----------------------------------------
  // Invalid and unknown words leave every strobe low, which is the idle behaviour.
  always_comb begin
    result = work_q;
    to_work = 1'b0;
    to_file = 1'b0;
    upd_zero = 1'b0;
    upd_carry = 1'b0;
    new_carry = flags_q.carry;
    if (insn.valid) begin
      unique case (op)
        omr_pkg::OMR_OR_LITERAL_INTO_WORK: begin
          result = work_q | lit;
          to_work = 1'b1;
          upd_zero = 1'b1;
        end
        omr_pkg::OMR_LOAD_LITERAL_TO_WORK: begin
          result = lit;
          to_work = 1'b1;
        end
        omr_pkg::OMR_OR_WORK_WITH_FILE: begin
          result = work_q | fval;
          to_work = ~dest_file;
          to_file = dest_file;
          upd_zero = 1'b1;
        end
        omr_pkg::OMR_STORE_WORK_TO_FILE: begin
          result = work_q;
          to_file = 1'b1;
        end
        omr_pkg::OMR_MOVE_FILE_TO_DEST: begin
          result = fval;
          to_work = ~dest_file;
          to_file = dest_file;
          upd_zero = 1'b1;
        end
        omr_pkg::OMR_ROTATE_LEFT_VIA_CARRY: begin
          result = rot_val;
          new_carry = fval[omr_pkg::MSB_BIT];
          to_work = ~dest_file;
          to_file = dest_file;
          upd_carry = 1'b1;
        end
        omr_pkg::OMR_RETURN_FROM_ISR: begin
        end
        omr_pkg::OMR_IDLE_INSTRUCTION: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Working register and flags
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      work_q <= omr_pkg::WORK_RESET;
    end else if (to_work) begin
      work_q <= result;
    end
  end

  // Outside reset the flag bits are only ever touched by their own update strobes, so the
  // idle and return operations leave them exactly as they were.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_q <= '0;
    end else begin
      if (upd_zero) begin
        flags_q.zero <= (result == 8'h00);
      end
      if (upd_carry) begin
        flags_q.carry <= new_carry;
      end
    end
  end

  // ----------------------------------------
  // File register space
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (to_file) begin
      file_mem[faddr] <= result;
    end
  end

  // Address and data follow every cycle; only file_we_q marks a real write-back.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      file_we_q <= 1'b0;
      file_addr_q <= 7'h00;
      file_wdata_q <= 8'h00;
    end else begin
      file_we_q <= to_file;
      file_addr_q <= faddr;
      file_wdata_q <= result;
    end
  end

  // ----------------------------------------
  // Return stack and interrupt enable
  // ----------------------------------------
  // The stack wraps silently like a circular buffer; overflow is not flagged.
  always_comb begin
    sp_d = sp_q;
    if (is_return) begin
      sp_d = sp_top;
    end else if (take_push) begin
      sp_d = sp_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sp_q <= 3'h0;
    end else begin
      sp_q <= sp_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (take_push) begin
      stack_q[sp_q] <= push_addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      program_counter_q <= omr_pkg::PC_RESET;
      pc_load_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
    end else begin
      pc_load_q <= 1'b0;
      if (is_return) begin
        program_counter_q <= stack_q[sp_top];
        pc_load_q <= 1'b1;
        global_irq_enable_q <= 1'b1;
      end
    end
  end
endmodule : omr_exec

// ===== sim/omr_exec_props.sv
// Purpose: Concurrent checks on the execution block ports.
// Assumes: One clock, synchronous active-high reset.
// Notes: Every check looks one cycle after an instruction is taken; the return check also looks one cycle later.
`timescale 1ns/1ps
module omr_exec_props (
  input wire logic core_clk,
  input wire logic reset,
  input omr_pkg::omr_insn_t insn,
  input wire logic [7:0] work_q,
  input omr_pkg::omr_flags_t flags_q,
  input wire logic global_irq_enable_q,
  input wire logic pc_load_q,
  input wire logic file_we_q,
  input wire logic [6:0] file_addr_q,
  input wire logic [7:0] file_wdata_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic v;
  logic [13:0] w;
  logic [6:0] fa;
  logic [7:0] lit;
  assign v = insn.valid;
  assign w = insn.word;
  assign fa = insn.word[6:0];
  assign lit = insn.word[7:0];
  logic is_ret;
  assign is_ret = v && (w == 14'h0009);
  AST_LOAD: assert property (v && w[13:10] == 4'hc |=>
    work_q == $past(lit) && $stable(flags_q))
    else $error("load literal wrong");
  AST_OR_LIT: assert property (v && w[13:8] == 6'h38 |=>
    work_q == ($past(work_q) | $past(lit)) && flags_q.zero == (work_q == 8'h00)
    && $stable(flags_q.carry))
    else $error("or literal wrong");
  AST_STORE: assert property (v && w[13:7] == 7'h01 |=> file_we_q
    && file_addr_q == $past(fa) && file_wdata_q == $past(work_q) && $stable(flags_q))
    else $error("store wrong");
  AST_DEST_F: assert property (v && w[7]
    && (w[13:8] == 6'h04 || w[13:8] == 6'h08) |=> file_we_q && file_addr_q == $past(fa)
    && $stable(work_q))
    else $error("file destination wrong");
  AST_OR_FILE: assert property (v && w[13:8] == 6'h04 |=>
    flags_q.zero == ((file_we_q ? file_wdata_q : work_q) == 8'h00)
    && ((file_we_q ? file_wdata_q : work_q) & $past(work_q)) == $past(work_q))
    else $error("or file wrong");
  AST_MOVE: assert property (v && w[13:8] == 6'h08 |=> $stable(flags_q.carry)
    && flags_q.zero == ((file_we_q ? file_wdata_q : work_q) == 8'h00))
    else $error("move zero wrong");
  AST_ROT: assert property (v && w[13:7] == 7'h1b |=> file_we_q
    && file_wdata_q[0] == $past(flags_q.carry) && $stable(flags_q.zero))
    else $error("rotate wrong");
  AST_RET: assert property (v && w == 14'h0009 |=> pc_load_q && global_irq_enable_q
    && $stable(flags_q) ##1 (!pc_load_q || $past(is_ret)))
    else $error("return wrong");
  AST_IDLE: assert property (v && w == 14'h0000 |=> $stable(work_q)
    && $stable(flags_q) && !file_we_q && !pc_load_q)
    else $error("idle changed state");
  COV_RET: cover property (v && w == 14'h0009);
  COV_ROT: cover property (v && w[13:8] == 6'h0d);
  COV_STORE: cover property (v && w[13:7] == 7'h01);
endmodule : omr_exec_props
bind omr_exec omr_exec_props i_omr_exec_props (.core_clk(core_clk), .reset(reset), .insn(insn),
  .work_q(work_q), .flags_q(flags_q), .global_irq_enable_q(global_irq_enable_q),
  .pc_load_q(pc_load_q), .file_we_q(file_we_q), .file_addr_q(file_addr_q),
  .file_wdata_q(file_wdata_q));

// ===== sim/omr_prog_mem.sv
// Purpose: Program memory model that hands one word per fetch.
// Assumes: The bench loads word_mem before asking for a fetch.
// Notes: Between fetches the word toggles so stale data is never reused.
`timescale 1ns/1ps
module omr_prog_mem (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic fetch_en,
  output omr_pkg::omr_insn_t insn
);
  logic [13:0] word_mem;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      insn <= '0;
    end else begin
      insn.valid <= fetch_en;
      insn.word <= fetch_en ? word_mem : ~insn.word;
    end
  end
endmodule : omr_prog_mem

// ===== sim/test_or_move_rotate_exec.sv
// Purpose: Self-checking bench for the execution block.
// Assumes: Program memory model feeds one instruction per fetch.
// Notes: Carry is tracked by hand across scenarios.
`timescale 1ns/1ps
module test_or_move_rotate_exec;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic fetch_en = 1'b0;
  logic push_valid = 1'b0;
  logic [12:0] push_addr = 13'h0000;
  omr_pkg::omr_insn_t insn;
  omr_pkg::omr_flags_t flags_q;
  logic [7:0] work_q;
  logic global_irq_enable_q;
  logic [12:0] program_counter_q;
  logic pc_load_q;
  logic file_we_q;
  logic [6:0] file_addr_q;
  logic [7:0] file_wdata_q;
  int miscompares = 0;
  int check_count = 0;
  omr_prog_mem i_omr_prog_mem (.core_clk(core_clk), .reset(reset), .fetch_en(fetch_en),
    .insn(insn));
  omr_exec i_omr_exec (.core_clk(core_clk), .reset(reset), .insn(insn),
    .push_valid(push_valid), .push_addr(push_addr), .work_q(work_q), .flags_q(flags_q),
    .global_irq_enable_q(global_irq_enable_q), .program_counter_q(program_counter_q),
    .pc_load_q(pc_load_q), .file_we_q(file_we_q), .file_addr_q(file_addr_q),
    .file_wdata_q(file_wdata_q));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task run(input logic [13:0] w);
    i_omr_prog_mem.word_mem = w;
    @(posedge core_clk) fetch_en <= 1'b1;
    @(posedge core_clk) fetch_en <= 1'b0;
    @(posedge core_clk) #1;
  endtask : run
  task t_literal;
    run({4'hc, 2'b11, 8'h00});
    chk({work_q, flags_q}, {8'h00, 2'b00});
    run({6'h38, 8'h00});
    chk({work_q, flags_q}, {8'h00, 2'b10});
    run({4'hc, 2'b00, 8'h5a});
    chk({work_q, flags_q}, {8'h5a, 2'b10});
    run({6'h38, 8'h81});
    chk({work_q, flags_q}, {8'hdb, 2'b00});
  endtask : t_literal
  task t_file;
    run(14'h00ff);
    chk({file_we_q, file_addr_q, file_wdata_q}, {1'b1, 7'h7f, 8'hdb});
    run({4'hc, 2'b00, 8'h00});
    run(14'h0083);
    chk(flags_q, 2'b00);
    run({6'h08, 1'b1, 7'h03});
    chk({file_we_q, file_addr_q, file_wdata_q, flags_q}, {1'b1, 7'h03, 8'h00, 2'b10});
    run({6'h08, 1'b0, 7'h7f});
    chk({file_we_q, work_q, flags_q}, {1'b0, 8'hdb, 2'b00});
    run({6'h04, 1'b1, 7'h03});
    chk({file_addr_q, file_wdata_q, flags_q}, {7'h03, 8'hdb, 2'b00});
  endtask : t_file
  task t_rotate;
    run({4'hc, 2'b00, 8'h81});
    run(14'h0085);
    run({6'h0d, 1'b0, 7'h05});
    chk({work_q, flags_q}, {8'h02, 2'b01});
    run({6'h0d, 1'b1, 7'h05});
    chk({file_wdata_q, work_q, flags_q}, {8'h03, 8'h02, 2'b01});
    run({4'hc, 2'b00, 8'h24});
    run({6'h04, 1'b0, 7'h05});
    chk({work_q, flags_q}, {8'h27, 2'b01});
  endtask : t_rotate
  task t_return;
    @(posedge core_clk) push_valid <= 1'b1;
    push_addr <= 13'h1abc;
    @(posedge core_clk) push_valid <= 1'b0;
    run(14'h0009);
    chk({pc_load_q, global_irq_enable_q, program_counter_q}, {2'b11, 13'h1abc});
    chk(flags_q, 2'b01);
    @(posedge core_clk) #1;
    chk(pc_load_q, 1'b0);
    run(14'h0000);
    chk({file_we_q, work_q, flags_q, global_irq_enable_q}, {1'b0, 8'h27, 2'b01, 1'b1});
  endtask : t_return
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_literal();
    t_file();
    t_rotate();
    t_return();
    finish_test();
  end
  // Roughly sixty cycles of work; the limit leaves a wide margin.
  initial begin
    repeat (2000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
endmodule : test_or_move_rotate_exec
